/* logic/acp_clk_div.sv */
`timescale 1ns/100ps
`default_nettype none
// Clock-enable divider: produces a 50 % square wave at clk divided by 2^sel for sel 1..3; sel 0 holds high.
module acp_clk_div (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic run_i,
   input wire logic [1:0] sel_i,
   output logic clk_o
);
   typedef struct packed {
      logic [2:0] cnt;
      logic q;
   } acp_div_t;
   acp_div_t st_r;
   acp_div_t st_nxt;
   logic [2:0] top;

   // Divide by 1 passes a level-high enable; otherwise toggle at half period.
   always_comb begin
      st_nxt = st_r;
      top = 3'((1 << sel_i) >> 1) - 3'h1;
      if (!run_i) begin
         st_nxt.cnt = 3'h0;
         st_nxt.q = 1'b0;
      end else if (sel_i == 2'h0) begin
         st_nxt.q = 1'b1;
      end else if (st_r.cnt >= top) begin
         st_nxt.cnt = 3'h0;
         st_nxt.q = ~st_r.q;
      end else begin
         st_nxt.cnt = st_r.cnt + 3'h1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign clk_o = st_r.q;
endmodule
`default_nettype wire

/* logic/acp_pkg.sv */
package acp_pkg;
   // Register addresses of the configuration slice.
   localparam logic [6:0] ADDR_IDREV = 7'h01;
   localparam logic [6:0] ADDR_CLKPWR = 7'h02;
   localparam logic [6:0] ADDR_CHPDN = 7'h03;
   localparam logic [6:0] ADDR_MISC = 7'h04;
   localparam logic [6:0] ADDR_MVOL_LO = 7'h07;
   localparam logic [6:0] ADDR_MUTE = 7'h13;
   localparam logic [6:0] PTR_RESET = 7'h01;
   localparam logic PTR_AUTOINC_RESET = 1'b1;
   // Identity fields; the part value is arbitrary, not a real part code.
   localparam logic [3:0] PART_CODE = 4'h5;
   localparam logic [3:0] REVISION_CODE = 4'h2;
   // Field positions of the clock and power register.
   localparam int CP_DRV_BIT = 7;
   localparam int CP_AUXDIV_LSB = 5;
   localparam int CP_MODDIV_LSB = 3;
   localparam int CP_OSC_BIT = 2;
   localparam int CP_STYLE_BIT = 1;
   localparam int CP_GPDN_BIT = 0;
   localparam logic [7:0] CLKPWR_RESET = 8'h81;
   localparam logic [7:0] CHPDN_RESET = 8'hFF;
   // Field positions of the misc register; bit 4 is reserved.
   localparam int MI_FMT_LSB = 5;
   localparam int MI_HOP_BIT = 3;
   localparam int MI_FRZ_BIT = 2;
   localparam int MI_EMPH_LSB = 0;
   localparam logic [7:0] MISC_RESET = 8'h20;
   localparam logic [7:0] MISC_WMASK = 8'hEF;
   localparam logic [2:0] FMT_RESERVED = 3'h7;
   localparam int NUM_CH = 8;
   localparam int NUM_VOL = 13;
   // Hopping divides the switch rate by 9/4.
   localparam logic [3:0] HOP_NUM = 4'h4;
   localparam logic [3:0] HOP_DEN = 4'h9;
endpackage

/* logic/acp_regs.sv */
// Contract
// - Pointer advances by one after each access when auto-increment is set.
// - Seven-bit pointer, reset 0000001, picks the register the next access uses.
// - All registers writable except identity, interrupt status and decimator output.
// - Address 01h reads part code high nibble and revision low nibble.
// - Auxiliary clock driver active while its enable bit is one, reset one.
// - Auxiliary divider codes 01,10,11 divide by 2,4,8; 00 uses strap.
// - Mute strap caught at reset release: low divides by 1, high by 2.
// - Modulator clock divider codes 00..11 divide by 1,2,4,8.
// - Oscillator power-down bit set stops the oscillator; default running.
// - Powered-down channel drives outputs low, or pos low neg high by style.
// - Global power-down, reset one, holds low power and keeps registers.
// - Eight channel power-down bits reset one halt processing of their channel.
// - Power-down change follows the ramp setting and output configuration.
// - Three-bit serial format select, default 001, picks audio port framing.
// - Hopping enabled only in global power-down; rate divided by 2.25 after relock.
// - Freeze stores volume and mute writes but holds the applied values.
// - Emphasis select: 00 none, 01 32k, 10 44.1k, 11 48k.
`timescale 1ns/100ps
`default_nettype none
module acp_regs (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   // Control port byte interface: a pointer load, a write or a read.
   input wire logic ptr_load_i,
   input wire logic [7:0] ptr_byte_i,
   input wire logic wr_i,
   input wire logic [7:0] wdata_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   output logic rvalid_o,
   // Pins and neighbouring blocks.
   input wire logic reset_pin_n_i,
   input wire logic mute_strap_i,
   input wire logic [acp_pkg::NUM_CH-1:0] ramp_done_i,
   input wire logic rate_locked_i,
   output logic aux_clock_out_o,
   output logic aux_clock_out_drive_en_o,
   output logic mod_clock_o,
   output logic osc_powerdown_o,
   output logic global_powerdown_o,
   output logic [acp_pkg::NUM_CH-1:0] ch_active_o,
   output logic [acp_pkg::NUM_CH-1:0] pwm_out_pos_force_o,
   output logic [acp_pkg::NUM_CH-1:0] pwm_out_neg_force_o,
   output logic [acp_pkg::NUM_CH-1:0] ch_halted_o,
   output logic [2:0] serial_format_sel_o,
   output logic [1:0] emphasis_filter_sel_o,
   output logic switch_rate_hop_en_o,
   output logic [3:0] hop_num_o,
   output logic [3:0] hop_den_o,
   output logic out_enable_o,
   output logic [7:0] vol_apply_o,
   output logic [3:0] vol_apply_idx_o
);
   localparam int NUM_CH_W = acp_pkg::NUM_CH;

   typedef struct packed {
      logic [6:0] ptr;
      logic autoinc;
      logic [7:0] clkpwr;
      logic [7:0] chpdn;
      logic [7:0] misc;
      logic [NUM_CH_W-1:0] ch_off;
      logic [7:0] rdata;
      logic rvalid;
      logic [1:0] rst_sync;
      logic rst_seen;
      logic strap;
      logic [1:0] strap_sync;
      logic [1:0] lock_sync;
      logic hop_wait;
      logic freeze_prev;
      logic [3:0] sweep;
      logic sweeping;
      logic [7:0] apply;
      logic [3:0] apply_idx;
   } acp_state_t;

   acp_state_t st_r;
   acp_state_t st_nxt;
   logic [7:0] vol_store [acp_pkg::NUM_VOL];
   logic [3:0] vol_idx;
   logic vol_hit;
   logic vol_wr;
   logic [1:0] aux_sel;
   logic aux_run;
   logic [7:0] rd_word;
   logic access;

   // Volume and mute addresses 07h..13h map to storage slots 0..12.
   assign vol_hit = (st_r.ptr >= acp_pkg::ADDR_MVOL_LO) && (st_r.ptr <= acp_pkg::ADDR_MUTE);
   assign vol_idx = 4'(st_r.ptr - acp_pkg::ADDR_MVOL_LO);
   assign vol_wr = wr_i && vol_hit;
   assign access = wr_i || rd_i;

   // Read mux; unmapped and reserved bits return zero.
   always_comb begin
      rd_word = 8'h00;
      if (st_r.ptr == acp_pkg::ADDR_IDREV) begin
         rd_word = {acp_pkg::PART_CODE, acp_pkg::REVISION_CODE};
      end else if (st_r.ptr == acp_pkg::ADDR_CLKPWR) begin
         rd_word = st_r.clkpwr;
      end else if (st_r.ptr == acp_pkg::ADDR_CHPDN) begin
         rd_word = st_r.chpdn;
      end else if (st_r.ptr == acp_pkg::ADDR_MISC) begin
         rd_word = st_r.misc & acp_pkg::MISC_WMASK;
      end else if (vol_hit) begin
         rd_word = vol_store[vol_idx];
      end
   end

   // Strap divider: code 00 uses the latched strap, else the field itself.
   always_comb begin
      aux_sel = st_r.clkpwr[acp_pkg::CP_AUXDIV_LSB +: 2];
      if (aux_sel == 2'h0) begin
         aux_sel = st_r.strap ? 2'h1 : 2'h0;
      end
   end
   assign aux_run = st_r.clkpwr[acp_pkg::CP_DRV_BIT] && !st_r.clkpwr[acp_pkg::CP_OSC_BIT];

   // Main next-state logic.
   always_comb begin
      st_nxt = st_r;
      st_nxt.rvalid = 1'b0;
      // Reset pin and lock are asynchronous; two flops before any use.
      st_nxt.rst_sync = {st_r.rst_sync[0], reset_pin_n_i};
      st_nxt.lock_sync = {st_r.lock_sync[0], rate_locked_i};
      st_nxt.strap_sync = {st_r.strap_sync[0], mute_strap_i};
      if (!st_r.rst_sync[1]) begin
         st_nxt.rst_seen = 1'b1;
      end else if (st_r.rst_seen) begin
         // Strap taken on the synchronised release of the reset pin.
         st_nxt.rst_seen = 1'b0;
         st_nxt.strap = st_r.strap_sync[1];
      end
      if (ptr_load_i) begin
         st_nxt.ptr = ptr_byte_i[6:0];
         st_nxt.autoinc = ptr_byte_i[7];
      end else if (access) begin
         if (rd_i) begin
            st_nxt.rdata = rd_word;
            st_nxt.rvalid = 1'b1;
         end
         if (wr_i) begin
            // Identity and other read-only words ignore writes.
            unique case (st_r.ptr)
               acp_pkg::ADDR_CLKPWR: st_nxt.clkpwr = wdata_i;
               acp_pkg::ADDR_CHPDN: st_nxt.chpdn = wdata_i;
               acp_pkg::ADDR_MISC: begin
                  st_nxt.misc = wdata_i & acp_pkg::MISC_WMASK;
                  // Hopping may only turn on while globally powered down.
                  if (!st_r.clkpwr[acp_pkg::CP_GPDN_BIT] && !st_r.misc[acp_pkg::MI_HOP_BIT]) begin
                     st_nxt.misc[acp_pkg::MI_HOP_BIT] = 1'b0;
                  end
                  // The reserved format code keeps the previous framing.
                  if (wdata_i[acp_pkg::MI_FMT_LSB +: 3] == acp_pkg::FMT_RESERVED) begin
                     st_nxt.misc[acp_pkg::MI_FMT_LSB +: 3] = st_r.misc[acp_pkg::MI_FMT_LSB +: 3];
                  end
               end
               default: begin
               end
            endcase
         end
         if (st_r.autoinc) begin
            st_nxt.ptr = st_r.ptr + 7'h01;
         end
      end
      // A channel is off once its bit is set and any ramp-down has ended.
      for (int i = 0; i < NUM_CH_W; i++) begin
         if (!st_r.chpdn[i]) begin
            st_nxt.ch_off[i] = 1'b0;
         end else if (ramp_done_i[i]) begin
            st_nxt.ch_off[i] = 1'b1;
         end
      end
      // Leaving power-down with hopping set waits for the converter to relock.
      if (st_r.clkpwr[acp_pkg::CP_GPDN_BIT]) begin
         st_nxt.hop_wait = st_r.misc[acp_pkg::MI_HOP_BIT];
      end else if (st_r.lock_sync[1]) begin
         st_nxt.hop_wait = 1'b0;
      end
      // On freeze release, replay every stored volume word once.
      st_nxt.freeze_prev = st_r.misc[acp_pkg::MI_FRZ_BIT];
      if (st_r.freeze_prev && !st_r.misc[acp_pkg::MI_FRZ_BIT]) begin
         st_nxt.sweeping = 1'b1;
         st_nxt.sweep = 4'h0;
      end else if (st_r.sweeping) begin
         st_nxt.apply = vol_store[st_r.sweep];
         st_nxt.apply_idx = st_r.sweep;
         if (st_r.sweep == 4'(acp_pkg::NUM_VOL - 1)) begin
            st_nxt.sweeping = 1'b0;
         end else begin
            st_nxt.sweep = st_r.sweep + 4'h1;
         end
      end else if (vol_wr && !st_r.misc[acp_pkg::MI_FRZ_BIT]) begin
         st_nxt.apply = wdata_i;
         st_nxt.apply_idx = vol_idx;
      end
   end

   // State register; stored registers keep contents through power-down.
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         st_r <= '0;
         st_r.ptr <= acp_pkg::PTR_RESET;
         st_r.autoinc <= acp_pkg::PTR_AUTOINC_RESET;
         st_r.clkpwr <= acp_pkg::CLKPWR_RESET;
         st_r.chpdn <= acp_pkg::CHPDN_RESET;
         st_r.misc <= acp_pkg::MISC_RESET;
         st_r.ch_off <= acp_pkg::CHPDN_RESET;
         st_r.rst_sync <= 2'h3;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Stored volume and mute words, written whether or not frozen.
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         for (int i = 0; i < acp_pkg::NUM_VOL; i++) begin
            vol_store[i] <= 8'h00;
         end
      end else begin
         if (vol_wr) begin
            vol_store[vol_idx] <= wdata_i;
         end
      end
   end

   // Divider for the auxiliary clock pin.
   acp_clk_div u_aux_div (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .run_i(aux_run),
      .sel_i(aux_sel),
      .clk_o(aux_clock_out_o)
   );

   // Divider for the modulator master clock; stops with the oscillator.
   acp_clk_div u_mod_div (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .run_i(!st_r.clkpwr[acp_pkg::CP_OSC_BIT]),
      .sel_i(st_r.clkpwr[acp_pkg::CP_MODDIV_LSB +: 2]),
      .clk_o(mod_clock_o)
   );

   // Output decode; power-down forces follow the selected output style.
   always_comb begin
      for (int i = 0; i < NUM_CH_W; i++) begin
         pwm_out_pos_force_o[i] = 1'b0;
         pwm_out_neg_force_o[i] = st_r.ch_off[i] && st_r.clkpwr[acp_pkg::CP_STYLE_BIT];
      end
   end

   assign rdata_o = st_r.rdata;
   assign rvalid_o = st_r.rvalid;
   assign aux_clock_out_drive_en_o = st_r.clkpwr[acp_pkg::CP_DRV_BIT];
   assign osc_powerdown_o = st_r.clkpwr[acp_pkg::CP_OSC_BIT];
   assign global_powerdown_o = st_r.clkpwr[acp_pkg::CP_GPDN_BIT];
   assign ch_halted_o = st_r.ch_off;
   assign ch_active_o = ~st_r.chpdn & {NUM_CH_W{~st_r.clkpwr[acp_pkg::CP_GPDN_BIT]}};
   assign serial_format_sel_o = st_r.misc[acp_pkg::MI_FMT_LSB +: 3];
   assign emphasis_filter_sel_o = st_r.misc[acp_pkg::MI_EMPH_LSB +: 2];
   assign switch_rate_hop_en_o = st_r.misc[acp_pkg::MI_HOP_BIT];
   assign hop_num_o = st_r.misc[acp_pkg::MI_HOP_BIT] ? acp_pkg::HOP_NUM : 4'h1;
   assign hop_den_o = st_r.misc[acp_pkg::MI_HOP_BIT] ? acp_pkg::HOP_DEN : 4'h1;
   assign out_enable_o = !st_r.clkpwr[acp_pkg::CP_GPDN_BIT] && !st_r.hop_wait;
   assign vol_apply_o = st_r.apply;
   assign vol_apply_idx_o = st_r.apply_idx;
endmodule
`default_nettype wire

/* tb/acp_host.sv */
`timescale 1ns/100ps
`default_nettype none
// Host controller on the control port; pointer load, write and read are separate tasks, so wr and rd use the current pointer.
// It leaves the freeze sequence to the test sequence.
module acp_host (
   input wire logic clk_i,
   output logic ptr_load_o,
   output logic [7:0] ptr_byte_o,
   output logic wr_o,
   output logic [7:0] wdata_o,
   output logic rd_o
);
   // Idle byte lanes show the inverse of their last value, so stale data never looks valid.
   initial begin
      ptr_load_o = 1'b0;
      ptr_byte_o = 8'h00;
      wr_o = 1'b0;
      wdata_o = 8'h00;
      rd_o = 1'b0;
   end
   task automatic ld(input logic [7:0] b);
      @(posedge clk_i);
      #1 ptr_byte_o = b;
      ptr_load_o = 1'b1;
      @(posedge clk_i);
      #1 ptr_load_o = 1'b0;
      ptr_byte_o = ~b;
   endtask
   task automatic wr(input logic [7:0] d);
      @(posedge clk_i);
      #1 wdata_o = d;
      wr_o = 1'b1;
      @(posedge clk_i);
      #1 wr_o = 1'b0;
      wdata_o = ~d;
   endtask
   task automatic rd();
      @(posedge clk_i);
      #1 rd_o = 1'b1;
      @(posedge clk_i);
      #1 rd_o = 1'b0;
   endtask
endmodule
`default_nettype wire

/* tb/acp_regs_properties.sv */
`timescale 1ns/100ps
`default_nettype none
module acp_regs_properties (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic rd_i,
   input wire logic rvalid_o,
   input wire logic aux_clock_out_o,
   input wire logic aux_clock_out_drive_en_o,
   input wire logic osc_powerdown_o,
   input wire logic global_powerdown_o,
   input wire logic [7:0] ch_active_o,
   input wire logic [7:0] pwm_out_pos_force_o,
   input wire logic [7:0] pwm_out_neg_force_o,
   input wire logic [2:0] serial_format_sel_o,
   input wire logic switch_rate_hop_en_o,
   input wire logic [3:0] hop_num_o,
   input wire logic [3:0] hop_den_o,
   input wire logic out_enable_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (sys_rst_i);
   // A read is answered by the valid pulse exactly one cycle later.
   sequence s_read_answer;
      rd_i ##1 rvalid_o;
   endsequence
   a_read_answer:
      assert property (rd_i |-> s_read_answer) else $error("read not answered next cycle");
   a_no_stray_valid:
      assert property (rvalid_o |-> $past(rd_i)) else $error("valid without a read");
   a_pos_low:
      assert property (pwm_out_pos_force_o == 8'h00) else $error("positive output forced high");
   a_neg_off_only:
      assert property ((pwm_out_neg_force_o & ch_active_o) == 8'h00)
         else $error("negative output forced on a live channel");
   a_gpdn_quiet:
      assert property (global_powerdown_o |-> ch_active_o == 8'h00 && !out_enable_o)
         else $error("activity during global power-down");
   a_hop_ratio:
      assert property (switch_rate_hop_en_o ? (hop_num_o == 4'h4 && hop_den_o == 4'h9)
         : (hop_num_o == 4'h1 && hop_den_o == 4'h1)) else $error("wrong switch rate ratio");
   a_hop_needs_pdn:
      assert property ($rose(switch_rate_hop_en_o) |-> global_powerdown_o)
         else $error("hopping enabled outside power-down");
   a_fmt_kept:
      assert property (serial_format_sel_o != 3'h7) else $error("reserved format taken");
   a_drv_off_quiet:
      assert property ((!aux_clock_out_drive_en_o)[*2] |-> !aux_clock_out_o)
         else $error("aux clock runs with driver off");
   a_osc_quiet:
      assert property (osc_powerdown_o[*2] |-> !aux_clock_out_o)
         else $error("aux clock runs with oscillator down");
endmodule
bind acp_regs acp_regs_properties acp_regs_properties_i (.clk_i, .sys_rst_i, .rd_i, .rvalid_o,
   .aux_clock_out_o, .aux_clock_out_drive_en_o, .osc_powerdown_o, .global_powerdown_o,
   .ch_active_o, .pwm_out_pos_force_o, .pwm_out_neg_force_o, .serial_format_sel_o,
   .switch_rate_hop_en_o, .hop_num_o, .hop_den_o, .out_enable_o);
`default_nettype wire

/* tb/test_amp_clock_power_config_regs.sv */
`timescale 1ns/100ps
`default_nettype none
module test_amp_clock_power_config_regs;
   logic clk_i, sys_rst_i, reset_pin_n_i, mute_strap_i, rate_locked_i, ptr_load_i, wr_i, rd_i;
   logic rvalid_o, aux_clock_out_o, aux_clock_out_drive_en_o, mod_clock_o, osc_powerdown_o;
   logic global_powerdown_o, switch_rate_hop_en_o, out_enable_o, seen_v;
   logic [7:0] ptr_byte_i, wdata_i, rdata_o, ramp_done_i, ch_active_o, pwm_out_pos_force_o;
   logic [7:0] pwm_out_neg_force_o, ch_halted_o, vol_apply_o, r, v, d;
   logic [3:0] hop_num_o, hop_den_o, vol_apply_idx_o;
   logic [2:0] serial_format_sel_o;
   logic [1:0] emphasis_filter_sel_o;
   logic [7:0] exp_q[$];
   int n_fail = 0;
   int n_tests = 0;
   int p;
   acp_host acp_host_i (.clk_i, .ptr_load_o(ptr_load_i), .ptr_byte_o(ptr_byte_i), .wr_o(wr_i),
      .wdata_o(wdata_i), .rd_o(rd_i));
   acp_regs acp_regs_i (.clk_i, .sys_rst_i, .ptr_load_i, .ptr_byte_i, .wr_i, .wdata_i, .rd_i,
      .rdata_o, .rvalid_o, .reset_pin_n_i, .mute_strap_i, .ramp_done_i, .rate_locked_i,
      .aux_clock_out_o, .aux_clock_out_drive_en_o, .mod_clock_o, .osc_powerdown_o,
      .global_powerdown_o, .ch_active_o, .pwm_out_pos_force_o, .pwm_out_neg_force_o,
      .ch_halted_o, .serial_format_sel_o, .emphasis_filter_sel_o, .switch_rate_hop_en_o,
      .hop_num_o, .hop_den_o, .out_enable_o, .vol_apply_o, .vol_apply_idx_o);
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   task automatic results();
      $display("tests %0d failures %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic check(input logic [7:0] got, input logic [7:0] want);
      n_tests++;
      if (got !== want) begin
         n_fail++;
         $display("unexpected at %0t: got %h want %h", $time, got, want);
      end
   endtask
   task automatic rd_exp(input logic [7:0] e);
      exp_q.push_back(e);
      acp_host_i.rd();
   endtask
   // Pointer loads keep auto-increment off so a following read sees the same register.
   task automatic wreg(input logic [6:0] a, input logic [7:0] dat);
      acp_host_i.ld({1'b0, a});
      acp_host_i.wr(dat);
      repeat (2) @(posedge clk_i);
      #1;
   endtask
   // Counts cycles between two rising edges of a divided clock; zero means it never ran.
   task automatic period(input logic aux, output int per);
      logic s, q;
      int rise1;
      per = 0;
      rise1 = -1;
      q = 1'b1;
      for (int k = 0; k < 64 && per == 0; k++) begin
         @(posedge clk_i);
         #2 s = aux ? aux_clock_out_o : mod_clock_o;
         if (s === 1'b1 && q === 1'b0) begin
            if (rise1 < 0) rise1 = k;
            else per = k - rise1;
         end
         q = s;
      end
   endtask
   // Each read answer is matched against the oldest expectation noted by the stimulus.
   always @(posedge clk_i) begin
      if (rvalid_o === 1'b1) begin
         if (exp_q.size() > 0) check(rdata_o, exp_q.pop_front());
         else check(8'h01, 8'h00);
      end
      if (vol_apply_idx_o === 4'h0 && vol_apply_o === v) seen_v <= 1'b1;
   end
   // A hang counts as a failure; the span is far above what the sequence needs.
   initial begin
      #100000;
      n_fail++;
      results();
   end
   initial begin
      sys_rst_i = 1'b1;
      reset_pin_n_i = 1'b0;
      mute_strap_i = 1'b1;
      rate_locked_i = 1'b0;
      ramp_done_i = 8'hFF;
      v = 8'h00;
      seen_v = 1'b0;
      p = $urandom(32'h11a2_778a);
      repeat (20) @(posedge clk_i);
      #1 sys_rst_i = 1'b0;
      repeat (2) @(posedge clk_i);
      #1 reset_pin_n_i = 1'b1;
      repeat (6) @(posedge clk_i);
      #1 mute_strap_i = 1'b0;
      // Reset values through the reset pointer with auto-increment on.
      rd_exp({acp_pkg::PART_CODE, acp_pkg::REVISION_CODE});
      rd_exp(8'h81);
      rd_exp(8'hFF);
      rd_exp(8'h20);
      period(1'b1, p);
      check(p[7:0], 8'h02);
      wreg(7'h01, 8'hFF);
      rd_exp({acp_pkg::PART_CODE, acp_pkg::REVISION_CODE});
      // Reserved format and bit are refused while hopping is accepted in power-down.
      wreg(7'h04, 8'hFF);
      rd_exp(8'h2F);
      check(switch_rate_hop_en_o, 8'h01);
      for (int f = 0; f < 7; f++) begin
         d = {f[2:0], 3'b000, f[1:0]};
         acp_host_i.wr(d);
         rd_exp(d);
         check(serial_format_sel_o, f[2:0]);
         check(emphasis_filter_sel_o, f[1:0]);
      end
      for (int c = 1; c < 4; c++) begin
         wreg(7'h02, {1'b1, c[1:0], c[1:0], 3'b001});
         period(1'b0, p);
         check(p[7:0], 8'h01 << c);
         period(1'b1, p);
         check(p[7:0], 8'h01 << c);
      end
      r = 8'($urandom());
      wreg(7'h03, r);
      rd_exp(r);
      wreg(7'h02, 8'h83);
      check(ch_active_o, 8'h00);
      wreg(7'h02, 8'h82);
      check(pwm_out_neg_force_o, r);
      check(ch_active_o, ~r);
      wreg(7'h02, 8'h80);
      check(pwm_out_neg_force_o, 8'h00);
      wreg(7'h04, 8'h28);
      rd_exp(8'h20);
      // Hopping set in power-down holds the output off until the converter relocks.
      wreg(7'h02, 8'h81);
      wreg(7'h04, 8'h28);
      rd_exp(8'h28);
      wreg(7'h02, 8'h80);
      repeat (4) @(posedge clk_i);
      #1;
      check(out_enable_o, 8'h00);
      rate_locked_i = 1'b1;
      for (int k = 0; k < 100 && out_enable_o !== 1'b1; k++) @(posedge clk_i);
      check(out_enable_o, 8'h01);
      // Freeze holds a volume write back until the bit is cleared.
      v = 8'($urandom()) | 8'h01;
      seen_v = 1'b0;
      wreg(7'h04, 8'h24);
      wreg(7'h07, v);
      check(seen_v, 8'h00);
      wreg(7'h04, 8'h20);
      repeat (20) @(posedge clk_i);
      check(seen_v, 8'h01);
      wreg(7'h02, 8'h04);
      check(aux_clock_out_drive_en_o, 8'h00);
      check(osc_powerdown_o, 8'h01);
      repeat (4) @(posedge clk_i);
      check(exp_q.size(), 8'h00);
      results();
   end
endmodule
`default_nettype wire
